// ---- core/uart_fifo_dma_wake_regs.v ----
// Local design decision: the APB register port.
`include "uart_regs_defines.vh"
`default_nettype none

// Notes on behaviour
// [R1] rts output follows pin-control bit 1, which resets to one.
// [R2] pin-control bit 0 reads the synchronised clear-to-send level.
// [R3] fifo register bit 8 shows parity error of the receive head character.
// [R4] with parity checking off the parity bit always reads zero.
// [R5] writing the data field pushes a character into the transmit fifo if room.
// [R6] reading the data field returns the receive fifo head character.
// [R7] reading pops it; empty reads zero; unused high bits read zero.
// [R8] dma bit 9 enables receive dma requests; resets disabled.
// [R9] receive dma request when receive level reaches threshold field 8:5.
// [R10] dma bit 4 enables transmit dma requests; resets disabled.
// [R11] transmit dma request while transmit level below threshold field 3:0.
// [R12] no dma request for a direction whose enable is cleared.
// [R13] wake enables: threshold bit 2, full bit 1, not empty bit 0.
// [R14] wake flags record those three events; software read/write; reset zero.
// [R15] wake output only when a flag and its enable are both set.
module uart_fifo_dma_wake_regs #(
	parameter AW = 3
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg rts_out,
	input wire cts_pin,
	input wire parity_enable,
	input wire [1:0] char_size,
	input wire rx_char_valid,
	input wire [7:0] rx_char_data,
	input wire rx_char_parity_err,
	output reg tx_char_valid,
	output reg [7:0] tx_char_data,
	input wire tx_char_ready,
	output reg rx_dma_req,
	output reg tx_dma_req,
	output reg wake_req,
	output reg irq
);
	localparam CW = AW + 1;

	reg cts_meta_q;
	reg cts_sync_q;
	reg cts_prev_q;
	reg [`DMA_W-1:0] dma_request_control_q;
	reg [`WK_W-1:0] wake_event_enable_q;
	reg [`WK_W-1:0] wake_event_flags_q;
	reg [`WK_W-1:0] wake_event_flags_d;
	reg [`EV_W-1:0] event_status_q;
	reg [`EV_W-1:0] event_status_d;
	reg [`EV_W-1:0] event_mask_q;
	reg rd_had_char_q;
	reg [31:0] rd_word;
	reg hit;

	wire access;
	wire done;
	wire wr_done;
	wire rd_done;
	wire [8:0] rx_head;
	wire rx_full;
	wire rx_empty;
	wire [CW-1:0] receive_fill_count;
	wire [7:0] tx_head;
	wire tx_full;
	wire tx_empty;
	wire [CW-1:0] transmit_fill_count;
	wire rx_push;
	wire rx_pop;
	wire tx_push;
	wire tx_pop;
	wire [3:0] rx_thd;
	wire [3:0] tx_thd;
	wire rx_at_thd;
	wire tx_below_thd;
	wire [`WK_W-1:0] wake_events;
	wire [`EV_W-1:0] hw_events;

	// mask of the bits a character of the given size really uses
	function [7:0] char_mask;
		input [1:0] sz;
		begin
			case (sz)
				`SZ_5: char_mask = 8'h1f;
				`SZ_6: char_mask = 8'h3f;
				`SZ_7: char_mask = 8'h7f;
				default: char_mask = 8'hff;
			endcase
		end
	endfunction

	// one wait state: data is prepared on the first access edge,
	// the transfer completes on the second
	assign access = psel & penable;
	assign done = access & pready;
	assign wr_done = done & pwrite;
	assign rd_done = done & ~pwrite;

	// receive path: parity flag stored only while checking is on
	assign rx_push = rx_char_valid & ~rx_full;
	assign rx_pop = rd_done & (paddr == `OFS_FIFO) & rd_had_char_q; // [R7]
	assign tx_push = wr_done & (paddr == `OFS_FIFO) & ~tx_full; // [R5]
	assign tx_pop = ~tx_empty & (~tx_char_valid | tx_char_ready);

	char_fifo #(
		.WIDTH(9),
		.AW(AW)
	) u_rx_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.push(rx_push),
		.push_data({rx_char_parity_err & parity_enable, rx_char_data}),
		.pop(rx_pop),
		.head_data(rx_head),
		.full(rx_full),
		.empty(rx_empty),
		.count(receive_fill_count)
	);

	char_fifo #(
		.WIDTH(8),
		.AW(AW)
	) u_tx_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.push(tx_push),
		.push_data(pwdata[`FIFO_DATA_HI:0]),
		.pop(tx_pop),
		.head_data(tx_head),
		.full(tx_full),
		.empty(tx_empty),
		.count(transmit_fill_count)
	);

	// threshold compares, zero-extended to a common width
	assign rx_thd = dma_request_control_q[`DMA_RXTHD_HI:`DMA_RXTHD_LO];
	assign tx_thd = dma_request_control_q[`DMA_TXTHD_HI:`DMA_TXTHD_LO];
	assign rx_at_thd = ~rx_empty &
		({4'h0, receive_fill_count} >= {{CW{1'b0}}, rx_thd}); // [R9]
	assign tx_below_thd =
		({4'h0, transmit_fill_count} < {{CW{1'b0}}, tx_thd}); // [R11]

	// wake conditions are levels of the receive fifo
	assign wake_events[`WK_THD] = rx_at_thd;
	assign wake_events[`WK_FULL] = rx_full;
	assign wake_events[`WK_NE] = ~rx_empty;

	// interrupt events: overrun, write into a full transmit fifo, cts edge
	assign hw_events[`EV_RXOVR] = rx_char_valid & rx_full;
	assign hw_events[`EV_TXDROP] = wr_done & (paddr == `OFS_FIFO) & tx_full;
	assign hw_events[`EV_CTS] = cts_sync_q ^ cts_prev_q;

	// read mux and address decode; unmapped addresses answer with pslverr
	always @*
	begin
		rd_word = 32'h0000_0000;
		hit = 1'b1;
		case (paddr)
			`OFS_PIN:
			begin
				rd_word[`PIN_RTS] = rts_out;
				rd_word[`PIN_CTS] = cts_sync_q; // [R2]
			end
			`OFS_FIFO:
			begin
				if (!rx_empty)
				begin
					rd_word[`FIFO_DATA_HI:0] = rx_head[7:0] & char_mask(char_size); // [R6] [R7]
					rd_word[`FIFO_PAR] = rx_head[8] & parity_enable; // [R3] [R4]
				end
			end
			`OFS_DMA: rd_word[`DMA_W-1:0] = dma_request_control_q;
			`OFS_WKEN: rd_word[`WK_W-1:0] = wake_event_enable_q;
			`OFS_WKFL: rd_word[`WK_W-1:0] = wake_event_flags_q;
			`OFS_EVST: rd_word[`EV_W-1:0] = event_status_q;
			`OFS_EVMASK: rd_word[`EV_W-1:0] = event_mask_q;
			`OFS_LEVEL:
			begin
				rd_word[`LVL_TX_LO +: CW] = transmit_fill_count;
				rd_word[`LVL_RX_LO +: CW] = receive_fill_count;
			end
			default: hit = 1'b0;
		endcase
	end

	// apb answer flops
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			rd_had_char_q <= 1'b0;
		end
		else
		begin
			pready <= access & ~pready;
			if (access & ~pready)
			begin
				prdata <= pwrite ? 32'h0000_0000 : rd_word;
				pslverr <= ~hit;
				// pop only the character that was returned, not one that
				// arrived after the snapshot
				rd_had_char_q <= ~rx_empty;
			end
			else
			begin
				prdata <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
		end
	end

	// cts pin synchroniser; only the second and third stages are looked at
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cts_meta_q <= `RST_CTS;
			cts_sync_q <= `RST_CTS;
			cts_prev_q <= `RST_CTS;
		end
		else
		begin
			cts_meta_q <= cts_pin;
			cts_sync_q <= cts_meta_q;
			cts_prev_q <= cts_sync_q;
		end
	end

	// wake flags: software writes, hardware sets, set wins
	always @*
	begin
		wake_event_flags_d = wake_event_flags_q;
		if (wr_done & (paddr == `OFS_WKFL))
			wake_event_flags_d = pwdata[`WK_W-1:0];
		wake_event_flags_d = wake_event_flags_d | wake_events; // [R14]
	end

	// event status: write one to clear, a new event wins over the clear
	always @*
	begin
		event_status_d = event_status_q;
		if (wr_done & (paddr == `OFS_EVST))
			event_status_d = event_status_d & ~pwdata[`EV_W-1:0];
		event_status_d = event_status_d | hw_events;
	end

	// software registers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rts_out <= `RST_RTS;
			dma_request_control_q <= `RST_DMA;
			wake_event_enable_q <= `RST_WK;
			wake_event_flags_q <= `RST_WK;
			event_status_q <= `RST_EV;
			event_mask_q <= `RST_EV;
		end
		else
		begin
			if (wr_done & (paddr == `OFS_PIN))
				rts_out <= pwdata[`PIN_RTS]; // [R1]
			if (wr_done & (paddr == `OFS_DMA))
				dma_request_control_q <= pwdata[`DMA_W-1:0]; // [R8] [R10]
			if (wr_done & (paddr == `OFS_WKEN))
				wake_event_enable_q <= pwdata[`WK_W-1:0]; // [R13]
			if (wr_done & (paddr == `OFS_EVMASK))
				event_mask_q <= pwdata[`EV_W-1:0];
			wake_event_flags_q <= wake_event_flags_d;
			event_status_q <= event_status_d;
		end
	end

	// transmit holding stage keeps the character output on a flop
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_char_valid <= 1'b0;
			tx_char_data <= 8'h00;
		end
		else if (tx_pop)
		begin
			tx_char_valid <= 1'b1;
			tx_char_data <= tx_head;
		end
		else if (tx_char_ready)
			tx_char_valid <= 1'b0;
	end

	// dma requests, wake and interrupt outputs, one cycle behind state
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_dma_req <= 1'b0;
			tx_dma_req <= 1'b0;
			wake_req <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			rx_dma_req <= dma_request_control_q[`DMA_RXEN] & rx_at_thd; // [R9] [R12]
			tx_dma_req <= dma_request_control_q[`DMA_TXEN] & tx_below_thd; // [R11] [R12]
			wake_req <= |(wake_event_flags_q & wake_event_enable_q); // [R15]
			irq <= |(event_status_q & event_mask_q);
		end
	end
endmodule // uart_fifo_dma_wake_regs

`default_nettype wire

// ---- core/uart_regs_defines.vh ----
`ifndef UART_REGS_DEFINES_VH
`define UART_REGS_DEFINES_VH

// register byte offsets on the apb bus
`define OFS_PIN 12'h01c
`define OFS_FIFO 12'h020
`define OFS_DMA 12'h030
`define OFS_WKEN 12'h034
`define OFS_WKFL 12'h038
`define OFS_EVST 12'h03c
`define OFS_EVMASK 12'h040
`define OFS_LEVEL 12'h044

// flow_pin_control fields
`define PIN_CTS 0
`define PIN_RTS 1
`define RST_RTS 1'b1
`define RST_CTS 1'b1

// char_fifo_access fields
`define FIFO_DATA_HI 7
`define FIFO_PAR 8

// dma_request_control fields
`define DMA_TXTHD_LO 0
`define DMA_TXTHD_HI 3
`define DMA_TXEN 4
`define DMA_RXTHD_LO 5
`define DMA_RXTHD_HI 8
`define DMA_RXEN 9
`define DMA_W 10
`define RST_DMA 10'h000

// wake_event_enable / wake_event_flags fields
`define WK_NE 0
`define WK_FULL 1
`define WK_THD 2
`define WK_W 3
`define RST_WK 3'h0

// event status / mask fields (write one to clear status)
`define EV_RXOVR 0
`define EV_TXDROP 1
`define EV_CTS 2
`define EV_W 3
`define RST_EV 3'h0

// fill level register fields
`define LVL_TX_LO 0
`define LVL_RX_LO 8

// character size codes: 0 five bits .. 3 eight bits
`define SZ_5 2'h0
`define SZ_6 2'h1
`define SZ_7 2'h2

`endif

// ---- core/char_fifo.v ----
`default_nettype none

// flip-flop fifo; depth must be a power of two so pointers wrap freely
module char_fifo #(
	parameter WIDTH = 9,
	parameter AW = 3
) (
	input wire pclk,
	input wire presetn,
	input wire push,
	input wire [WIDTH-1:0] push_data,
	input wire pop,
	output wire [WIDTH-1:0] head_data,
	output wire full,
	output wire empty,
	output wire [AW:0] count
);
	localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

	reg [WIDTH-1:0] mem [0:(1<<AW)-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;
	wire do_push;
	wire do_pop;

	// refuse a push when full and a pop when empty
	assign do_push = push & ~full;
	assign do_pop = pop & ~empty;
	assign full = (count_q == DEPTH);
	assign empty = (count_q == {(AW+1){1'b0}});
	assign count = count_q;
	assign head_data = mem[rd_ptr_q];

	// storage holds no control state, so it is left without reset
	always @(posedge pclk)
	begin
		if (do_push)
			mem[wr_ptr_q] <= push_data;
	end

	// pointers and fill count
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (do_push)
				wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
			if (do_pop)
				rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
			if (do_push & ~do_pop)
				count_q <= count_q + {{AW{1'b0}}, 1'b1};
			else if (do_pop & ~do_push)
				count_q <= count_q - {{AW{1'b0}}, 1'b1};
		end
	end
endmodule // char_fifo

`default_nettype wire

// ---- tb/uart_regs_properties.sv ----
`include "uart_regs_defines.vh"
`default_nettype none
module uart_regs_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rts_out,
	input wire logic parity_enable,
	input wire logic tx_char_valid,
	input wire logic [7:0] tx_char_data,
	input wire logic tx_char_ready,
	input wire logic rx_dma_req,
	input wire logic tx_dma_req
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// completed transfers by place; the design answers after exactly one wait
	wire logic done = psel && penable && pready;
	wire logic rd = done && !pwrite;
	wire logic wr_pin = done && pwrite && paddr == `OFS_PIN;
	wire logic mapped = paddr inside {`OFS_PIN, `OFS_FIFO, `OFS_DMA, `OFS_WKEN,
		`OFS_WKFL, `OFS_EVST, `OFS_EVMASK, `OFS_LEVEL};
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	a_one_wait: assert property (s_setup ##1 s_access |=> pready)
		else $error("pready not in second access cycle");
	a_rts_write: assert property (wr_pin |=> rts_out == $past(pwdata[1]))
		else $error("rts does not follow write");
	a_pin_read: assert property (rd && paddr == `OFS_PIN |-> prdata[31:1] == rts_out)
		else $error("pin register read wrong");
	a_par_off: assert property (rd && paddr == `OFS_FIFO && !parity_enable
		&& !$past(parity_enable) |-> !prdata[8]) else $error("parity flag with parity off");
	a_fifo_rsvd: assert property (rd && paddr == `OFS_FIFO |-> prdata[31:9] == 0)
		else $error("fifo read high bits set");
	a_rx_dma_off: assert property (rd && paddr == `OFS_DMA
		&& !prdata[9] |-> !rx_dma_req) else $error("rx dma request while disabled");
	a_tx_dma_off: assert property (rd && paddr == `OFS_DMA
		&& !prdata[4] |-> !tx_dma_req) else $error("tx dma request while disabled");
	a_tx_hold: assert property (tx_char_valid && !tx_char_ready
		|=> tx_char_valid && $stable(tx_char_data)) else $error("tx char dropped early");
	a_err_unmapped: assert property (done && !mapped |-> pslverr && prdata == 0)
		else $error("unmapped access not refused");
endmodule // uart_regs_properties
bind uart_fifo_dma_wake_regs uart_regs_properties i_uart_regs_properties (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rts_out,
	.parity_enable, .tx_char_valid, .tx_char_data, .tx_char_ready, .rx_dma_req, .tx_dma_req);
`default_nettype wire

// ---- tb/flow_partner.sv ----
`default_nettype none
// remote serial device: a stall drops its ready line and our cts
module flow_partner (
	input wire logic pclk,
	input wire logic slow,
	input wire logic tx_char_valid,
	output logic tx_char_ready,
	output logic cts_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic n = 1'b0;
	// take a char only every other cycle, so answers come both at once and late
	always @(posedge pclk) n <= ~n;
	assign tx_char_ready = tx_char_valid && !slow && n;
	assign cts_pin = !slow;
endmodule // flow_partner
`default_nettype wire

// ---- tb/uart_fifo_dma_wake_regs_test.sv ----
`include "uart_regs_defines.vh"
`default_nettype none
module uart_fifo_dma_wake_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic parity_enable = 1'b0, rx_char_valid = 1'b0, rx_char_parity_err = 1'b0, slow = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, seed = 32'haf2d, rq[$], tq[$], xq[$];
	logic [1:0] char_size = 2'h3;
	logic [7:0] rx_char_data = 8'h0, d;
	logic err, p;
	wire logic [31:0] prdata;
	wire logic [7:0] tx_char_data;
	wire logic pready, pslverr, rts_out, cts_pin, tx_char_valid, tx_char_ready;
	wire logic rx_dma_req, tx_dma_req, wake_req, irq;
	int fails = 0, checked = 0, cyc = 0, i;
	always #5 pclk = ~pclk;
	uart_fifo_dma_wake_regs i_uart_fifo_dma_wake_regs (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rts_out, .cts_pin,
		.parity_enable, .char_size, .rx_char_valid, .rx_char_data, .rx_char_parity_err,
		.tx_char_valid, .tx_char_data, .tx_char_ready, .rx_dma_req, .tx_dma_req, .wake_req, .irq);
	flow_partner i_flow_partner (.pclk, .slow, .tx_char_valid, .tx_char_ready, .cts_pin);
	function logic [31:0] nx(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task close_out;
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// apb master: hold the request until pready is seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task rx(input logic [7:0] v, input logic pe);
		@(posedge pclk);
		rx_char_valid <= 1'b1;
		rx_char_data <= v;
		rx_char_parity_err <= pe;
		@(posedge pclk);
		rx_char_valid <= 1'b0;
	endtask
	// watcher: every read answer and every char handed out meets the oldest note
	always @(posedge pclk)
	begin
		if (pready === 1'b1 && !pwrite)
			check(prdata, rq.pop_front());
		if (tx_char_valid === 1'b1 && tx_char_ready === 1'b1)
			check(tx_char_data, tq.pop_front());
		// a hang ends here as a mismatch, never as a pass
		if (++cyc == 5000)
		begin
			fails++;
			close_out;
		end
	end
	initial
	begin
		tick(2);
		presetn <= 1'b1;
		check(rts_out, 1'b1);
		rd(`OFS_PIN, 32'h3);
		rd(`OFS_DMA, 32'h0);
		rd(`OFS_WKEN, 32'h0);
		rd(`OFS_WKFL, 32'h0);
		rd(`OFS_FIFO, 32'h0);
		rd(12'h100, 32'h0);
		check(err, 1'b1);
		apb(1'b1, `OFS_PIN, 32'h0);
		tick(1);
		check(rts_out, 1'b0);
		slow <= 1'b1;
		tick(4);
		rd(`OFS_PIN, 32'h0);
		slow <= 1'b0;
		tick(4);
		rd(`OFS_PIN, 32'h1);
		apb(1'b1, `OFS_PIN, 32'h2);
		// every char size, parity checking on and off, random data and error
		for (i = 0; i < 8; i++)
		begin
			seed = nx(seed);
			d = seed[7:0];
			p = seed[8];
			parity_enable <= i[2];
			char_size <= i[1:0];
			rx(d, p);
			rd(`OFS_FIFO, {p & i[2], d & (8'hff >> (2'h3 - i[1:0]))});
		end
		rd(`OFS_FIFO, 32'h0);
		// thresholds rx 2, tx 3, both enabled, far side stalled
		apb(1'b1, `OFS_DMA, 32'h253);
		slow <= 1'b1;
		tick(2);
		check(rx_dma_req, 1'b0);
		for (i = 0; i < 2; i++)
		begin
			seed = nx(seed);
			rx(seed[7:0], 1'b0);
			xq.push_back(seed[7:0]);
			tick(2);
			check(rx_dma_req, i == 1);
		end
		// one char sits in the holding stage, so the tenth write finds the fifo full
		for (i = 0; i < 10; i++)
		begin
			seed = nx(seed);
			if (i < 9)
				tq.push_back(seed[7:0]);
			apb(1'b1, `OFS_FIFO, seed[7:0]);
			tick(4);
			check(tx_dma_req, i < 3);
		end
		apb(1'b1, `OFS_DMA, 32'h43);
		slow <= 1'b0;
		tick(20);
		check(tx_dma_req, 1'b0);
		check(rx_dma_req, 1'b0);
		rd(`OFS_DMA, 32'h43);
		for (i = 0; i < 2; i++)
			rd(`OFS_FIFO, xq.pop_front());
		// wake flags stick, the output needs a flag and its enable
		apb(1'b1, `OFS_DMA, 32'h0);
		check(wake_req, 1'b0);
		rd(`OFS_WKFL, 32'h5);
		apb(1'b1, `OFS_WKFL, 32'h0);
		rd(`OFS_WKFL, 32'h0);
		apb(1'b1, `OFS_WKEN, 32'h1);
		rd(`OFS_WKEN, 32'h1);
		check(wake_req, 1'b0);
		for (i = 0; i < 9; i++)
		begin
			seed = nx(seed);
			rx(seed[7:0], 1'b0);
			if (i < 8)
				xq.push_back(seed[7:0]);
		end
		tick(3);
		check(wake_req, 1'b1);
		rd(`OFS_WKFL, 32'h7);
		// overrun, dropped write and cts change events: mask, then clear
		rd(`OFS_EVST, 32'h7);
		apb(1'b1, `OFS_EVMASK, 32'h7);
		tick(2);
		check(irq, 1'b1);
		apb(1'b1, `OFS_EVMASK, 32'h0);
		tick(2);
		check(irq, 1'b0);
		// unmask again so that only the clear can bring the line down
		apb(1'b1, `OFS_EVMASK, 32'h7);
		apb(1'b1, `OFS_EVST, 32'h7);
		rd(`OFS_EVST, 32'h0);
		tick(2);
		check(irq, 1'b0);
		for (i = 0; i < 8; i++)
			rd(`OFS_FIFO, xq.pop_front());
		tick(4);
		check(tq.size(), 32'h0);
		close_out;
	end
endmodule // uart_fifo_dma_wake_regs_test
`default_nettype wire
